// *** hw/smps_pkg.sv ***
// Shared constants and carrier types for the power supply control core
package smps_pkg;
    localparam int CLK_MHZ = 200;
    localparam int CLK_HZ = CLK_MHZ * 1000000;
    localparam int SS_STEPS = 32;
    localparam int SS_LVL_W = 6;
    localparam int SS_STEP_US = 600;
    localparam int SS_STEP_CYC = SS_STEP_US * CLK_MHZ;
    localparam int SS_END_MS = 20;
    localparam int SS_END_CYC = SS_END_MS * 1000 * CLK_MHZ;
    localparam int BLANK_MS = 20;
    localparam int BLANK_CYC = BLANK_MS * 1000 * CLK_MHZ;
    localparam int SPIKE_US = 30;
    localparam int SPIKE_CYC = SPIKE_US * CLK_MHZ;
    localparam int LEB_NS = 220;
    localparam int LEB_CYC = (LEB_NS * CLK_MHZ + 500) / 1000;
    localparam int LEB_W = 6;
    localparam int TMR_W = 23;
    localparam int OSC_W = 12;
    localparam int OSC_HZ = 65000;
    localparam int OSC_PER = (CLK_HZ + OSC_HZ / 2) / OSC_HZ;
    localparam int JIT_HZ = 2600;
    localparam int JIT_DEV = (OSC_PER * JIT_HZ + OSC_HZ / 2) / OSC_HZ;
    localparam int JIT_MS = 4;
    localparam int JIT_STEP_CYC = (JIT_MS * 1000 * CLK_MHZ) / (4 * JIT_DEV);
    localparam int DMAX_NUM = 3;
    localparam int DMAX_SHIFT = 2;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
    localparam logic CTRL_EN_RST = 1'h1;
    localparam int CTRL_EN_BIT = 0;
    localparam int ST_GATE_BIT = 0;
    localparam int ST_SS_BIT = 1;
    localparam int ST_BURST_BIT = 2;
    localparam int ST_AR_BIT = 3;
    localparam int ST_CLAMP_BIT = 4;
    localparam int ST_LVL_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {ST_OFF, ST_SOFT, ST_NORM, ST_BURST, ST_AR} mode_e;

    typedef struct packed {
        logic uvlo_ok;
        logic pwm_cmp;
        logic current_limit_cmp;
        logic burst_limit_cmp;
        logic fb_low_cmp;
        logic fb_high_cmp;
        logic blank_pin_level_cmp;
    } cmp_s;

    typedef struct packed {
        logic cycle_start;
        logic on_window;
        logic [OSC_W-1:0] on_cnt;
        logic [OSC_W-1:0] on_max;
    } osc_s;
endpackage : smps_pkg

// *** hw/smps_jitter_osc.sv ***
// Switching oscillator with triangular frequency jitter and duty ceiling
`timescale 1ns/1ps
module smps_jitter_osc
    import smps_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic jitter_en,
    output osc_s osc
);
    logic [OSC_W-1:0] cnt_q;
    logic signed [OSC_W-1:0] jit_q;
    logic up_q;
    logic [OSC_W-1:0] step_q;
    logic [OSC_W-1:0] per;
    logic [OSC_W+1:0] on3;

    assign per = OSC_W'(OSC_PER) + OSC_W'(jit_q);
    assign on3 = (OSC_W+2)'(per) * (OSC_W+2)'(DMAX_NUM);
    assign osc.cycle_start = (cnt_q == '0);
    assign osc.on_max = OSC_W'(on3 >> DMAX_SHIFT);
    assign osc.on_window = (cnt_q < osc.on_max);
    assign osc.on_cnt = cnt_q;

    // Period may shrink mid-cycle, so wrap on reaching or passing it
    always_ff @(posedge aclk) begin
        if (!aresetn || cnt_q >= per - OSC_W'(1)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + OSC_W'(1);
        end
    end

    // Jitter held at zero until normal operation
    always_ff @(posedge aclk) begin
        if (!aresetn || !jitter_en) begin
            jit_q <= '0;
            up_q <= 1'b1;
            step_q <= '0;
        end else if (step_q == OSC_W'(JIT_STEP_CYC - 1)) begin
            step_q <= '0;
            if (up_q) begin
                if (jit_q == OSC_W'(JIT_DEV)) begin
                    up_q <= 1'b0;
                end else begin
                    jit_q <= jit_q + OSC_W'(1);
                end
            end else begin
                if (jit_q == -OSC_W'(JIT_DEV)) begin
                    up_q <= 1'b1;
                end else begin
                    jit_q <= jit_q - OSC_W'(1);
                end
            end
        end else begin
            step_q <= step_q + OSC_W'(1);
        end
    end
endmodule : smps_jitter_osc

// *** hw/smps_ctrl_core.sv ***
// Soft start, PWM latch and burst / auto-restart control core
// Functional notes
// - Soft start begins when supply lockout releases
// - Limit level rises in 32 discrete steps
// - Counter advances every 600 us
// - Soft start ends at 20 ms, sink off
// - Allowed duty grows from zero to maximum
// - Soft start reruns on each auto-restart attempt
// - Oscillator 65 kHz, +/-2.6 kHz, 4 ms jitter
// - On-time never exceeds 0.75 of period
// - Jitter enabled only after soft start ends
// - Latch set by oscillator, cleared by comparators
// - Latch clear turns gate off immediately
// - Gate held low under supply lockout
// - Current-limit trip ends cycle at once
// - Current sense ignored 220 ns after turn-on
// - Reduced 0.34 V limit only in burst
// - 20 ms blanking before burst or restart
// - Release clamp, then wait for pin charged
// - 30 us spike blanking before auto-restart
// - Burst fixed blanking; restart also capacitor-extended
// - Startup cell off throughout burst mode
// - Burst counter runs while feedback low
// - Overload counter runs while feedback high
// - Feedback high leaves burst, drops reduced limit
// - Lockout clears the soft start counter
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module smps_ctrl_core
    import smps_pkg::*;
#(
    parameter int unsigned SS_STEP = SS_STEP_CYC,
    parameter int unsigned SS_END = SS_END_CYC,
    parameter int unsigned BLANK = BLANK_CYC,
    parameter int unsigned SPIKE = SPIKE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input cmp_s cmp_in,
    output logic gate_on,
    output logic blank_pin_clamp_switch,
    output logic startup_cell_en,
    output logic [SS_LVL_W-1:0] soft_start_level,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    cmp_s s1_q, s2_q;
    mode_e st_q;
    osc_s osc;
    logic en_q;
    logic pwm_latch_q;
    logic [LEB_W-1:0] leb_q;
    logic [TMR_W-1:0] ss_tmr_q, ss_step_q;
    logic [SS_LVL_W-1:0] lvl_q;
    logic [TMR_W-1:0] burst_blk_q, ovl_blk_q, spike_q;
    logic clamp_q, startup_q;
    logic aw_q, w_q, bvalid_q, rvalid_q;
    logic [ADDR_W-1:0] awa_q;
    logic [31:0] wdata_q, rdata_q, stat;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic run, leb_active, ss_trip, cs_trip, latch_set, latch_clr;
    logic burst_limit_gate, blank_expire_gate, autorestart_and_gate;
    logic [OSC_W+SS_LVL_W-1:0] ss_prod;
    logic [OSC_W-1:0] ss_limit;
    logic jitter_en, ss_tick, ar_go;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        return (a == CTRL_OFS) || (a == STAT_OFS);
    endfunction : reg_hit

    // Comparator outputs are asynchronous to aclk
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= cmp_in;
            s2_q <= s1_q;
        end
    end

    smps_jitter_osc u_osc (
        .aclk(aclk),
        .aresetn(aresetn),
        .jitter_en(jitter_en),
        .osc(osc)
    );

    assign jitter_en = (st_q == ST_NORM) || (st_q == ST_BURST);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_OFF;
        end else if (!s2_q.uvlo_ok) begin
            st_q <= ST_OFF;
        end else begin
            case (st_q)
                ST_OFF: begin
                    st_q <= ST_SOFT;
                end
                ST_SOFT: begin
                    if (ss_tmr_q == TMR_W'(SS_END - 1)) begin
                        st_q <= ST_NORM;
                    end
                end
                ST_NORM: begin
                    if (s2_q.fb_low_cmp &&
                        burst_blk_q == TMR_W'(BLANK - 1)) begin
                        st_q <= ST_BURST;
                    end else if (ar_go) begin
                        st_q <= ST_AR;
                    end
                end
                ST_BURST: begin
                    if (s2_q.fb_high_cmp) begin
                        st_q <= ST_NORM;
                    end
                end
                ST_AR: begin
                    st_q <= ST_AR;
                end
                default: begin
                    st_q <= ST_OFF;
                end
            endcase
        end
    end

    // soft start timer in clock cycles
    always_ff @(posedge aclk) begin
        if (!aresetn || st_q != ST_SOFT) begin
            ss_tmr_q <= '0;
        end else begin
            ss_tmr_q <= ss_tmr_q + TMR_W'(1);
        end
    end

    assign ss_tick = (ss_step_q == TMR_W'(SS_STEP - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn || st_q != ST_SOFT || ss_tick) begin
            ss_step_q <= '0;
        end else begin
            ss_step_q <= ss_step_q + TMR_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !s2_q.uvlo_ok || st_q == ST_OFF) begin
            lvl_q <= '0;
        end else if (st_q == ST_SOFT && ss_tick &&
                     lvl_q != SS_LVL_W'(SS_STEPS)) begin
            lvl_q <= lvl_q + SS_LVL_W'(1);
        end
    end
    assign soft_start_level = lvl_q;

    // duty ceiling scales with the level
    assign ss_prod = (OSC_W+SS_LVL_W)'(osc.on_max) *
                     (OSC_W+SS_LVL_W)'(lvl_q);
    assign ss_limit = OSC_W'(ss_prod >> $clog2(SS_STEPS));
    assign ss_trip = (st_q == ST_SOFT) && (osc.on_cnt >= ss_limit);

    always_ff @(posedge aclk) begin
        if (!aresetn || st_q != ST_NORM || !s2_q.fb_low_cmp) begin
            burst_blk_q <= '0;
        end else if (burst_blk_q != TMR_W'(BLANK - 1)) begin
            burst_blk_q <= burst_blk_q + TMR_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || st_q != ST_NORM || !s2_q.fb_high_cmp) begin
            ovl_blk_q <= '0;
        end else if (ovl_blk_q != TMR_W'(BLANK - 1)) begin
            ovl_blk_q <= ovl_blk_q + TMR_W'(1);
        end
    end

    assign blank_expire_gate = (ovl_blk_q == TMR_W'(BLANK - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clamp_q <= 1'b1;
        end else begin
            clamp_q <= !blank_expire_gate;
        end
    end
    assign blank_pin_clamp_switch = clamp_q;

    // restart also waits for the pin
    assign autorestart_and_gate = (st_q == ST_NORM) && !clamp_q &&
                                  s2_q.fb_high_cmp &&
                                  s2_q.blank_pin_level_cmp;

    always_ff @(posedge aclk) begin
        if (!aresetn || !autorestart_and_gate) begin
            spike_q <= '0;
        end else if (!ar_go) begin
            spike_q <= spike_q + TMR_W'(1);
        end
    end
    // Conditions must still hold on the last count, not only before it
    assign ar_go = autorestart_and_gate && (spike_q == TMR_W'(SPIKE - 1));

    // startup cell kept off in burst
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            startup_q <= 1'b0;
        end else begin
            startup_q <= !s2_q.uvlo_ok && (st_q != ST_BURST);
        end
    end
    assign startup_cell_en = startup_q;

    assign burst_limit_gate = (st_q == ST_BURST);

    assign run = en_q && s2_q.uvlo_ok &&
                 (st_q == ST_SOFT || st_q == ST_NORM || st_q == ST_BURST);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            leb_q <= '0;
        end else if (latch_set) begin
            leb_q <= LEB_W'(LEB_CYC);
        end else if (leb_active) begin
            leb_q <= leb_q - LEB_W'(1);
        end
    end
    assign leb_active = (leb_q != '0);

    // sense trips only act on an open latch
    assign cs_trip = pwm_latch_q && !leb_active &&
                     (s2_q.pwm_cmp || s2_q.current_limit_cmp ||
                      (burst_limit_gate && s2_q.burst_limit_cmp));

    assign latch_set = osc.cycle_start && run;
    assign latch_clr = cs_trip || ss_trip || !osc.on_window || !run;
    always_ff @(posedge aclk) begin
        if (!aresetn || latch_clr) begin
            pwm_latch_q <= 1'b0;
        end else if (latch_set) begin
            pwm_latch_q <= 1'b1;
        end
    end
    assign gate_on = pwm_latch_q;

    // Write channel: address and data taken in either order
    assign awready = !aw_q && !bvalid_q;
    assign wready = !w_q && !bvalid_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_q <= 1'b1;
                awa_q <= awaddr;
            end else if (aw_q && w_q) begin
                aw_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end else if (aw_q && w_q) begin
                w_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (aw_q && w_q) begin
            bvalid_q <= 1'b1;
            bresp_q <= reg_hit(awa_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    // Software enable gates switching without touching soft start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_q <= CTRL_EN_RST;
        end else if (aw_q && w_q && awa_q == CTRL_OFS && wstrb_q[0]) begin
            en_q <= wdata_q[CTRL_EN_BIT];
        end
    end

    always_comb begin
        stat = '0;
        stat[ST_GATE_BIT] = pwm_latch_q;
        stat[ST_SS_BIT] = (st_q == ST_SOFT);
        stat[ST_BURST_BIT] = (st_q == ST_BURST);
        stat[ST_AR_BIT] = (st_q == ST_AR);
        stat[ST_CLAMP_BIT] = clamp_q;
        stat[ST_LVL_LSB +: SS_LVL_W] = lvl_q;
    end

    // Read answer registered on the same edge that takes the address
    assign arready = !rvalid_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= reg_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
            if (araddr == CTRL_OFS) begin
                rdata_q <= 32'(en_q) << CTRL_EN_BIT;
            end else if (araddr == STAT_OFS) begin
                rdata_q <= stat;
            end else begin
                rdata_q <= '0;
            end
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    gate_uvlo_a: assert property (
        !s2_q.uvlo_ok |=> !gate_on
    ) else $error("gate on under lockout");

    max_duty_a: assert property (
        gate_on |-> $past(osc.on_window) && osc.on_cnt <= $past(osc.on_max)
    ) else $error("duty ceiling exceeded");

    leb_hold_a: assert property (
        gate_on && leb_active && s2_q.current_limit_cmp && run
        && !ss_trip && osc.on_window |=> gate_on
    ) else $error("trip not blanked");

    cl_trip_a: assert property (
        gate_on && !leb_active && s2_q.current_limit_cmp |=> !gate_on
    ) else $error("current limit missed");

    // burst limit active only in burst
    burst_limit_a: assert property (
        gate_on && !leb_active && s2_q.burst_limit_cmp
        && st_q == ST_BURST |=> !gate_on
    ) else $error("burst limit missed");

    // level moves one step at a time
    ss_step_a: assert property (
        lvl_q != $past(lvl_q) |->
        lvl_q == '0 || lvl_q == $past(lvl_q) + SS_LVL_W'(1)
    ) else $error("soft start level jump");

    ss_end_a: assert property (
        st_q == ST_SOFT && s2_q.uvlo_ok &&
        ss_tmr_q == TMR_W'(SS_END - 1) |=> st_q == ST_NORM
    ) else $error("soft start overran");

    ss_zero_a: assert property (
        st_q == ST_SOFT && lvl_q == '0 |=> !gate_on
    ) else $error("pulse at zero level");

    ss_nojit_a: assert property (
        st_q == ST_SOFT |->
        osc.on_max == OSC_W'(OSC_PER * DMAX_NUM >> DMAX_SHIFT)
    ) else $error("jitter during soft start");

    startup_off_a: assert property (
        st_q == ST_BURST |-> !startup_cell_en
    ) else $error("startup cell on in burst");

    burst_exit_a: assert property (
        st_q == ST_BURST && s2_q.fb_high_cmp |=> st_q != ST_BURST
    ) else $error("burst not left");

    ar_entry_a: assert property (
        $rose(st_q == ST_AR) |->
        $past(s2_q.blank_pin_level_cmp && !clamp_q)
    ) else $error("restart before pin charged");

    ss_clear_a: assert property (
        !s2_q.uvlo_ok |=> lvl_q == '0
    ) else $error("level kept through lockout");

    burst_entry_c: cover property ($rose(st_q == ST_BURST));
    ar_entry_c: cover property ($rose(st_q == ST_AR));
    ss_done_c: cover property (st_q == ST_SOFT ##1 st_q == ST_NORM);
endmodule : smps_ctrl_core

// *** verif/smps_sense_model.sv ***
// Behavioural sense comparators, supply monitor and blanking pin
`timescale 1ns/1ps
module smps_sense_model
    import smps_pkg::*;
(
    input wire logic aclk,
    input wire logic gate_on,
    input wire logic blank_pin_clamp_switch,
    input wire logic uvlo_ok,
    input wire logic fb_low,
    input wire logic fb_high,
    input wire logic [1:0] trip_sel,
    input wire logic [11:0] trip_at,
    input wire logic [7:0] chg_cyc,
    output cmp_s cmp
);
    logic [11:0] on_q;
    logic [7:0] chg_q;
    logic ramp;

    // Sense ramp restarts each turn-on; sense reads low while switch is off
    always_ff @(posedge aclk) begin
        on_q <= gate_on ? on_q + 12'h001 : 12'h000;
    end

    // Pin charges only while the clamp is open; saturates to avoid wrap
    always_ff @(posedge aclk) begin
        if (blank_pin_clamp_switch) begin
            chg_q <= 8'h00;
        end else if (chg_q != 8'hFF) begin
            chg_q <= chg_q + 8'h01;
        end
    end

    assign ramp = gate_on && (on_q >= trip_at);
    assign cmp.uvlo_ok = uvlo_ok;
    assign cmp.pwm_cmp = ramp && (trip_sel == 2'h2);
    assign cmp.current_limit_cmp = ramp && (trip_sel == 2'h1);
    assign cmp.burst_limit_cmp = ramp && (trip_sel == 2'h3);
    assign cmp.fb_low_cmp = fb_low;
    assign cmp.fb_high_cmp = fb_high;
    assign cmp.blank_pin_level_cmp = !blank_pin_clamp_switch
        && (chg_q >= chg_cyc);
endmodule : smps_sense_model

// *** verif/smps_ctrl_core_bench.sv ***
// Self-checking bench for the power supply control core
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module smps_ctrl_core_bench
    import smps_pkg::*;
;
    localparam int STEP_T = 20;
    localparam int BLANK_T = 50;
    logic aclk, aresetn, gate_on, clamp, cell_en;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [SS_LVL_W-1:0] level;
    logic uvlo, fb_low, fb_high;
    logic [1:0] trip_sel;
    logic [11:0] trip_at;
    cmp_s cmp;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int hi, t0, rise, p0;
    logic [1:0] sels[4] = '{2'h1, 2'h1, 2'h2, 2'h3};
    logic [11:0] ats[4] = '{12'h00A, 12'h064, 12'h064, 12'h064};
    // Window end moves with the jittered period
    int lo[4] = '{LEB_CYC, 100, 100,
        (OSC_PER - JIT_DEV) * DMAX_NUM >> DMAX_SHIFT};
    int up[4] = '{LEB_CYC + 4, 106, 106,
        (OSC_PER + JIT_DEV) * DMAX_NUM >> DMAX_SHIFT};

    smps_ctrl_core #(.SS_STEP(STEP_T), .SS_END(700), .BLANK(BLANK_T),
        .SPIKE(10)) dut_u (.aclk(aclk), .aresetn(aresetn), .cmp_in(cmp),
        .gate_on(gate_on), .blank_pin_clamp_switch(clamp),
        .startup_cell_en(cell_en), .soft_start_level(level),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

    smps_sense_model model_u (.aclk(aclk), .gate_on(gate_on),
        .blank_pin_clamp_switch(clamp), .uvlo_ok(uvlo), .fb_low(fb_low),
        .fb_high(fb_high), .trip_sel(trip_sel), .trip_at(trip_at),
        .chg_cyc(8'h1E), .cmp(cmp));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    always @(posedge aclk) cyc <= cyc + 1;

    task automatic wrap_up();
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw;
        logic w;
        @(posedge aclk);
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    // Skips a pulse already under way so only whole pulses are timed
    task automatic pulse();
        hi = 0;
        while (gate_on !== 1'b0) @(posedge aclk);
        do @(posedge aclk); while (gate_on !== 1'b1);
        rise = cyc;
        while (gate_on === 1'b1) begin
            @(posedge aclk);
            hi++;
        end
    endtask : pulse

    // Counts gate-on cycles over at least one switching period, the longest jittered period being 3200 cycles
    task automatic quiet();
        hi = 0;
        repeat (3200) begin
            @(posedge aclk);
            if (gate_on !== 1'b0) hi++;
        end
    endtask : quiet

    initial begin
        repeat (90000) @(posedge aclk);
        num_errors++;
        wrap_up();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {uvlo, fb_low, fb_high, trip_sel} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        trip_at = 12'hFFF;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK("clamp", 1'b1, clamp)
        repeat (5) @(posedge aclk);
        `CHK("gate", 1'b0, gate_on)
        rd(CTRL_OFS);
        `CHK("ctrl", 32'h1, d)
        rd(8'h10);
        `CHK("rresp", RESP_SLVERR, r)
        `CHK("rdata", 32'h0, d)
        wr(8'h10, 32'h0);
        `CHK("bresp", RESP_SLVERR, r)
        wr(STAT_OFS, 32'h0);
        `CHK("bresp", RESP_OKAY, r)
        rd(STAT_OFS);
        `CHK("ss idle", 1'b0, d[ST_SS_BIT])
        uvlo <= 1'b1;
        t0 = cyc;
        while (level !== 6'h01) @(posedge aclk);
        hi = cyc;
        while (level !== 6'h02) @(posedge aclk);
        `CHK("step", STEP_T, cyc - hi)
        rd(STAT_OFS);
        `CHK("ss run", 1'b1, d[ST_SS_BIT])
        while (cyc < t0 + 680) @(posedge aclk);
        `CHK("level", 6'h20, level)
        while (cyc < t0 + 720) @(posedge aclk);
        rd(STAT_OFS);
        `CHK("ss end", 1'b0, d[ST_SS_BIT])
        pulse();
        p0 = rise;
        pulse();
        hi = rise - p0 - OSC_PER;
        `CHK("period", 1'b1, hi * hi <= (JIT_DEV + 2) ** 2)
        for (int i = 0; i < 4; i++) begin
            trip_sel <= sels[i];
            trip_at <= ats[i];
            pulse();
            `CHK("on", 1'b1, hi>=lo[i] && hi<=up[i])
        end
        trip_sel <= 2'h0;
        wr(CTRL_OFS, 32'h0);
        quiet();
        `CHK("off", 0, hi)
        wr(CTRL_OFS, 32'h1);
        fb_low <= 1'b1;
        repeat (30) @(posedge aclk);
        fb_low <= 1'b0;
        rd(STAT_OFS);
        `CHK("burst early", 1'b0, d[ST_BURST_BIT])
        fb_low <= 1'b1;
        repeat (60) @(posedge aclk);
        rd(STAT_OFS);
        `CHK("burst", 1'b1, d[ST_BURST_BIT])
        `CHK("cell", 1'b0, cell_en)
        trip_sel <= 2'h3;
        pulse();
        `CHK("burst on", 1'b1, hi >= 100 && hi <= 106)
        {trip_sel, fb_low, fb_high} <= 4'h1;
        repeat (8) @(posedge aclk);
        fb_high <= 1'b0;
        rd(STAT_OFS);
        `CHK("burst exit", 1'b0, d[ST_BURST_BIT])
        fb_high <= 1'b1;
        t0 = cyc;
        while (clamp !== 1'b0) @(posedge aclk);
        `CHK("blank", 1'b1, cyc - t0 >= BLANK_T && cyc - t0 <= BLANK_T + 6)
        t0 = cyc;
        while (cyc < t0 + 36) @(posedge aclk);
        rd(STAT_OFS);
        `CHK("ar early", 1'b0, d[ST_AR_BIT])
        repeat (30) @(posedge aclk);
        rd(STAT_OFS);
        `CHK("ar", 1'b1, d[ST_AR_BIT])
        quiet();
        `CHK("ar gate", 0, hi)
        {uvlo, fb_high} <= 2'h0;
        repeat (6) @(posedge aclk);
        `CHK("level clr", 6'h00, level)
        `CHK("gate lo", 1'b0, gate_on)
        `CHK("cell on", 1'b1, cell_en)
        uvlo <= 1'b1;
        while (level !== 6'h01) @(posedge aclk);
        rd(STAT_OFS);
        `CHK("ss rerun", 1'b1, d[ST_SS_BIT])
        wrap_up();
    end
endmodule : smps_ctrl_core_bench
